// ==== rtl/sensor_window_blanking_defines.svh ====
// Offsets, field widths, reset values and limits of the window/blanking bank
// Function
// - Frame-synced registers apply pending writes at frame start unless hold bit set
// - Frame start is first dark row, by default eight rows before frame_valid
// - Non-synced settings are stored and used at once; here they reach the outputs one edge late
// - Masked-bad-frame writes suppress the resulting frame unless bad frames shown
// - Row start is 11 bits, first image row; values below 8 avoided
// - Column start is 11 bits, first image column; below 0x18 avoided
// - Window height sets image rows per frame, resets to 0x400
// - Window width sets image columns per row, resets to 0x500
// - Context bit 0 set selects 11-bit context-B horizontal blanking
// - Horizontal blanking below minimum uses minimum: 202 full, 114 low power
// - Context bit 1 set selects 15-bit context-B vertical blanking, reset 0x2a
// - Vertical blanking change never marks a bad frame
// - Context bit 0 clear uses context-A horizontal blanking
`ifndef SENSOR_WINDOW_BLANKING_DEFINES_SVH
`define SENSOR_WINDOW_BLANKING_DEFINES_SVH

`define SWB_ADDR_CHIP_VERSION   8'h00
`define SWB_ADDR_FIRST_ROW      8'h01
`define SWB_ADDR_FIRST_COLUMN   8'h02
`define SWB_ADDR_WINDOW_ROWS    8'h03
`define SWB_ADDR_WINDOW_COLUMNS 8'h04
`define SWB_ADDR_HBLANK_B       8'h05
`define SWB_ADDR_VBLANK_B       8'h06

`define SWB_WIN_W               11
`define SWB_VBLANK_W            15

`define SWB_RST_FIRST_ROW       11'h00c
`define SWB_RST_FIRST_COLUMN    11'h01e
`define SWB_RST_WINDOW_ROWS     11'h400
`define SWB_RST_WINDOW_COLUMNS  11'h500
`define SWB_RST_HBLANK_B        11'h184
`define SWB_RST_VBLANK_B        15'h002a

`define SWB_HBLANK_MIN_FULL     11'h0ca
`define SWB_HBLANK_MIN_LOW      11'h072
`define SWB_DARK_ROW_LEAD       8'h08

`endif

// ==== rtl/sensor_window_blanking_pkg.sv ====
// Types shared by the window/blanking register bank
package sensor_window_blanking_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [7:0]  reg_addr_t;
    typedef logic [10:0] win_field_t;
    typedef logic [14:0] vblank_field_t;
endpackage

// ==== rtl/sensor_window_blanking_regs.sv ====
// Window and context-B blanking registers with frame-start shadowing
`timescale 1ns/1ps
`default_nettype none
`include "sensor_window_blanking_defines.svh"

module sensor_window_blanking_regs #(
    parameter logic [15:0] CHIP_VERSION = 16'h5a01 // Arbitrary identity value
) (
    input  wire logic                                       clk,             // 20 MHz
    input  wire logic                                       rst_n,           // Sync reset
    input  wire sensor_window_blanking_pkg::reg_addr_t      reg_addr,        // Register number
    input  wire logic                                       reg_wr,          // Write strobe
    input  wire sensor_window_blanking_pkg::reg_word_t      reg_wdata,       // Write data
    input  wire logic                                       reg_rd,          // Read strobe
    output logic                                            reg_rvalid,      // Read data valid
    output sensor_window_blanking_pkg::reg_word_t           reg_rdata,       // Read data
    input  wire logic                                       frame_start,     // First dark row pulse
    input  wire logic                                       sync_hold,       // Synchronize-changes bit
    input  wire logic                                       hblank_ctx_b,    // Context select bit 0
    input  wire logic                                       vblank_ctx_b,    // Context select bit 1
    input  wire sensor_window_blanking_pkg::win_field_t     hblank_a,        // Context-A hblank
    input  wire sensor_window_blanking_pkg::vblank_field_t  vblank_a,        // Context-A vblank
    input  wire logic                                       low_power,       // Low-power readout
    input  wire logic                                       show_bad_frames, // Let bad frames out
    output sensor_window_blanking_pkg::win_field_t          first_row,       // Active row start
    output sensor_window_blanking_pkg::win_field_t          first_column,    // Active column start
    output sensor_window_blanking_pkg::win_field_t          window_rows,     // Active height
    output sensor_window_blanking_pkg::win_field_t          window_columns,  // Active width
    output sensor_window_blanking_pkg::win_field_t          hblank_used,     // Effective hblank
    output sensor_window_blanking_pkg::vblank_field_t       vblank_used,     // Effective vblank
    output logic                                            suppress_frame,  // Drop current frame
    output logic                                            masked_bad_frame_flag // Bad frame pending
);

    // Timing: a write lands in the pending copy at the next edge and reads
    // back from there; the active copy and the registered data outputs move
    // one edge after a frame start with the hold bit clear. Context select,
    // the context-A values and the power mode reach the outputs one edge
    // late as well, the price of keeping every data output in a flip-flop.

    // Index of each shadowed register in the pending/active arrays
    localparam int N_SYNC = 6;
    localparam int I_ROW  = 0;
    localparam int I_COL  = 1;
    localparam int I_HGT  = 2;
    localparam int I_WID  = 3;
    localparam int I_HBB  = 4;
    localparam int I_VBB  = 5;

    // Registers whose change may disturb a frame; vertical blanking is not one
    localparam logic [N_SYNC-1:0] BAD_MASK = 6'b01_1111;

    function automatic sensor_window_blanking_pkg::win_field_t clamp_hblank(
        input sensor_window_blanking_pkg::win_field_t val,
        input logic                                   lp
    );
        sensor_window_blanking_pkg::win_field_t min_v;
        min_v = lp ? `SWB_HBLANK_MIN_LOW : `SWB_HBLANK_MIN_FULL;
        return (val < min_v) ? min_v : val;
    endfunction

    function automatic int addr_index(
        input sensor_window_blanking_pkg::reg_addr_t a
    );
        int idx;
        idx = -1;
        case (a)
            `SWB_ADDR_FIRST_ROW:      idx = I_ROW;
            `SWB_ADDR_FIRST_COLUMN:   idx = I_COL;
            `SWB_ADDR_WINDOW_ROWS:    idx = I_HGT;
            `SWB_ADDR_WINDOW_COLUMNS: idx = I_WID;
            `SWB_ADDR_HBLANK_B:       idx = I_HBB;
            `SWB_ADDR_VBLANK_B:       idx = I_VBB;
            default:                  idx = -1;
        endcase
        return idx;
    endfunction

    function automatic sensor_window_blanking_pkg::reg_word_t reset_value(
        input int idx
    );
        sensor_window_blanking_pkg::reg_word_t v;
        v = 16'h0000;
        case (idx)
            I_ROW:   v = {5'h00, `SWB_RST_FIRST_ROW};
            I_COL:   v = {5'h00, `SWB_RST_FIRST_COLUMN};
            I_HGT:   v = {5'h00, `SWB_RST_WINDOW_ROWS};
            I_WID:   v = {5'h00, `SWB_RST_WINDOW_COLUMNS};
            I_HBB:   v = {5'h00, `SWB_RST_HBLANK_B};
            I_VBB:   v = {1'b0, `SWB_RST_VBLANK_B};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // Field width mask: upper bits of every shadowed register read back as zero
    function automatic sensor_window_blanking_pkg::reg_word_t field_mask(
        input int idx
    );
        return (idx == I_VBB) ? 16'h7fff : 16'h07ff;
    endfunction

    // Only the six shadowed registers accept writes
    function automatic logic mapped(
        input int idx
    );
        return idx >= 0;
    endfunction

    sensor_window_blanking_pkg::reg_word_t pend_q   [N_SYNC];
    sensor_window_blanking_pkg::reg_word_t pend_d   [N_SYNC];
    sensor_window_blanking_pkg::reg_word_t act_q    [N_SYNC];
    sensor_window_blanking_pkg::reg_word_t act_d    [N_SYNC];
    logic [N_SYNC-1:0]                     dirty_q;
    logic [N_SYNC-1:0]                     dirty_d;
    logic                                  bad_q;
    logic                                  bad_d;
    logic                                  rvalid_q;
    logic                                  rvalid_d;
    sensor_window_blanking_pkg::reg_word_t rdata_q;
    sensor_window_blanking_pkg::reg_word_t rdata_d;
    logic [N_SYNC-1:0]                     write_hit;

    // Registered data outputs
    sensor_window_blanking_pkg::win_field_t    hblank_sel;
    sensor_window_blanking_pkg::win_field_t    hblank_q;
    sensor_window_blanking_pkg::win_field_t    hblank_d;
    sensor_window_blanking_pkg::vblank_field_t vblank_q;
    sensor_window_blanking_pkg::vblank_field_t vblank_d;
    logic                                      suppress_q;
    logic                                      suppress_d;

    logic                                  transfer;
    int                                    wr_idx;
    int                                    rd_idx;

    // Frame start marks the first dark row, not the rise of frame_valid
    assign transfer = frame_start && !sync_hold;

    assign wr_idx = addr_index(reg_addr);
    assign rd_idx = addr_index(reg_addr);

    always_comb
    begin
        write_hit = '0;
        if (reg_wr && mapped(wr_idx))
        begin
            write_hit[wr_idx] = 1'b1;
        end
    end

    // Shadow group: pending copies take writes, active copies take frames
    always_comb
    begin
        for (int i = 0; i < N_SYNC; i++)
        begin
            pend_d[i] = pend_q[i];
            act_d[i]  = act_q[i];
        end
        if (transfer)
        begin
            for (int i = 0; i < N_SYNC; i++)
            begin
                act_d[i] = pend_q[i];
            end
        end
        // A write in the transfer cycle stays pending for the next frame
        if (reg_wr && mapped(wr_idx))
        begin
            pend_d[wr_idx] = reg_wdata & field_mask(wr_idx);
        end
    end

    // Bad-frame group: masked writes since the last transfer
    always_comb
    begin
        dirty_d = dirty_q;
        bad_d   = bad_q;
        if (transfer)
        begin
            // A frame started after a masked change may carry mixed rows
            bad_d   = |(dirty_q & BAD_MASK);
            dirty_d = '0;
        end
        // Set wins over the clear: the write belongs to the next frame
        dirty_d = dirty_d | write_hit;
    end

    always_comb
    begin
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        if (reg_rd)
        begin
            if (reg_addr == `SWB_ADDR_CHIP_VERSION)
                rdata_d = CHIP_VERSION;
            else if (rd_idx >= 0)
                rdata_d = pend_q[rd_idx];
            else
                rdata_d = 16'h0000;
        end
    end

    // Shadow registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N_SYNC; i++)
            begin
                pend_q[i] <= reset_value(i);
                act_q[i]  <= reset_value(i);
            end
        end
        else
        begin
            for (int i = 0; i < N_SYNC; i++)
            begin
                pend_q[i] <= pend_d[i];
                act_q[i]  <= act_d[i];
            end
        end
    end

    // Flag registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dirty_q <= '0;
            bad_q   <= 1'b0;
        end
        else
        begin
            dirty_q <= dirty_d;
            bad_q   <= bad_d;
        end
    end

    // Read registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 16'h0000;
        end
        else
        begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
        end
    end

    // Output group: follows the next active copy so a transfer shows at once
    always_comb
    begin
        // Context select is not shadowed: a flip shows at the next edge
        if (hblank_ctx_b)
        begin
            hblank_sel = act_d[I_HBB][10:0];
        end
        else
        begin
            hblank_sel = hblank_a;
        end
        // The minimum applies in either context
        hblank_d = clamp_hblank(hblank_sel, low_power);
        // Software must keep this at least the dark row count; not checked
        if (vblank_ctx_b)
        begin
            vblank_d = act_d[I_VBB][14:0];
        end
        else
        begin
            vblank_d = vblank_a;
        end
        suppress_d = bad_d && !show_bad_frames;
    end

    // Registered outputs cost one cycle of latency on the context inputs
    always_ff @(posedge clk)
    begin
        hblank_q <= hblank_d;
        vblank_q <= vblank_d;
        if (!rst_n)
        begin
            suppress_q <= 1'b0;
        end
        else
        begin
            suppress_q <= suppress_d;
        end
    end

    assign reg_rvalid     = rvalid_q;
    assign reg_rdata      = rdata_q;
    assign first_row      = act_q[I_ROW][10:0];
    assign first_column   = act_q[I_COL][10:0];
    assign window_rows    = act_q[I_HGT][10:0];
    assign window_columns = act_q[I_WID][10:0];

    assign hblank_used           = hblank_q;
    assign vblank_used           = vblank_q;
    assign masked_bad_frame_flag = bad_q;
    assign suppress_frame        = suppress_q;

endmodule
`default_nettype wire

// ==== bench/swb_regs_asserts.sv ====
// Concurrent checks on the window/blanking register bank ports
`timescale 1ns/1ps
`default_nettype none
module swb_checker (
    input wire logic        clk,             // Clock
    input wire logic        rst_n,           // Reset
    input wire logic        reg_rd,          // Read
    input wire logic        reg_rvalid,      // Valid
    input wire logic        frame_start,     // Frame
    input wire logic        sync_hold,       // Hold
    input wire logic        hblank_ctx_b,    // Ctx 0
    input wire logic        vblank_ctx_b,    // Ctx 1
    input wire logic [10:0] hblank_a,        // A h
    input wire logic [14:0] vblank_a,        // A v
    input wire logic        low_power,       // Mode
    input wire logic        show_bad_frames, // Show
    input wire logic [10:0] first_row,       // Row
    input wire logic [10:0] hblank_used,     // H
    input wire logic [14:0] vblank_used,     // V
    input wire logic        suppress_frame,  // Drop
    input wire logic        masked_bad_frame_flag // Bad
);
    wire logic [10:0] hmin = low_power ? 11'h072 : 11'h0ca;
    wire logic        xfer = frame_start && !sync_hold;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_read;
        reg_rd ##1 reg_rvalid;
    endsequence
    a_read_answer: assert property (reg_rd |-> s_read)
        else $error("read not answered");
    a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("stray read valid");
    a_active_hold: assert property (!xfer |=> $stable(first_row))
        else $error("active row start moved");
    a_flag_at_xfer: assert property ($changed(masked_bad_frame_flag) |-> $past(xfer))
        else $error("bad flag moved off transfer");
    a_hblank_floor: assert property (hblank_used >= $past(hmin))
        else $error("hblank below minimum");
    a_hblank_a: assert property (!$past(hblank_ctx_b) |->
        hblank_used == (($past(hblank_a) < $past(hmin))
                        ? $past(hmin) : $past(hblank_a)))
        else $error("context A hblank wrong");
    a_vblank_a: assert property (!$past(vblank_ctx_b) |->
        vblank_used == $past(vblank_a))
        else $error("context A vblank wrong");
    a_suppress_rule: assert property (suppress_frame ==
        (masked_bad_frame_flag && !$past(show_bad_frames)))
        else $error("suppress wrong");
endmodule
bind sensor_window_blanking_regs swb_checker swb_checker_inst (.clk, .rst_n,
    .reg_rd, .reg_rvalid, .frame_start, .sync_hold, .hblank_ctx_b,
    .vblank_ctx_b, .hblank_a, .vblank_a, .low_power, .show_bad_frames,
    .first_row, .hblank_used, .vblank_used, .suppress_frame,
    .masked_bad_frame_flag);
`default_nettype wire

// ==== bench/tb_top.sv ====
// Directed testbench for the window/blanking register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [15:0] CV = 16'h0a5c; // Arbitrary identity value
    logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, frame_start = 0;
    logic sync_hold = 0, hblank_ctx_b = 0, vblank_ctx_b = 0;
    logic low_power = 0, show_bad_frames = 0, reg_rvalid, suppress_frame;
    logic masked_bad_frame_flag;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [10:0] hblank_a = 11'h050, first_row, first_column, window_rows;
    logic [10:0] window_columns, hblank_used;
    logic [14:0] vblank_a = 15'h0011, vblank_used;
    logic [15:0] rv [7] = '{CV, 16'h000c, 16'h001e, 16'h0400, 16'h0500,
                            16'h0184, 16'h002a};
    int fails = 0, checks = 0;
    sensor_window_blanking_regs #(.CHIP_VERSION(CV))
        sensor_window_blanking_regs_inst (.clk, .rst_n, .reg_addr, .reg_wr,
        .reg_wdata, .reg_rd, .reg_rvalid, .reg_rdata, .frame_start,
        .sync_hold, .hblank_ctx_b, .vblank_ctx_b, .hblank_a, .vblank_a,
        .low_power, .show_bad_frames, .first_row, .first_column,
        .window_rows, .window_columns, .hblank_used, .vblank_used,
        .suppress_frame, .masked_bad_frame_flag);
    initial forever #25 clk = ~clk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk({15'h0, reg_rvalid}, 16'h1);
        chk(reg_rdata, e);
    endtask
    task automatic frame(input logic h);
        @(posedge clk);
        {frame_start, sync_hold} <= {1'b1, h};
        @(posedge clk);
        {frame_start, sync_hold} <= 2'h0;
        #1;
    endtask
    // Order: show_bad_frames, hblank_ctx_b, vblank_ctx_b, low_power
    task automatic ctl(input logic [3:0] v);
        @(posedge clk);
        {show_bad_frames, hblank_ctx_b, vblank_ctx_b, low_power} <= v;
        @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        fails++;
        give_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(i), rv[i]);
        rd(8'h07, 16'h0000);
        wr(8'h00, 16'hffff);
        rd(8'h00, CV);
        wr(8'h03, 16'hf123);
        rd(8'h03, 16'h0123);
        wr(8'h01, 16'h0010);
        wr(8'h02, 16'h0020);
        wr(8'h04, 16'h0321);
        chk(16'(window_rows), 16'h0400);
        frame(1'b1);
        chk(16'(window_rows), 16'h0400);
        chk(16'(first_row), 16'h000c);
        frame(1'b0);
        chk(16'(window_rows), 16'h0123);
        chk(16'(first_row), 16'h0010);
        chk(16'(first_column), 16'h0020);
        chk(16'(window_columns), 16'h0321);
        chk(16'(suppress_frame), 16'h1);
        ctl(4'h8);
        chk(16'(suppress_frame), 16'h0);
        wr(8'h06, 16'hffff);
        rd(8'h06, 16'h7fff);
        frame(1'b0);
        chk(16'(masked_bad_frame_flag), 16'h0);
        ctl(4'h6);
        chk(16'(vblank_used), 16'h7fff);
        chk(16'(hblank_used), 16'h0184);
        wr(8'h05, 16'h0010);
        frame(1'b0);
        chk(16'(hblank_used), 16'h00ca);
        ctl(4'h7);
        chk(16'(hblank_used), 16'h0072);
        wr(8'h05, 16'h0300);
        frame(1'b0);
        chk(16'(hblank_used), 16'h0300);
        ctl(4'h1);
        chk(16'(hblank_used), 16'h0072);
        give_verdict;
    end
endmodule
`default_nettype wire
